/* core/fcc_counter_port.sv */
// Frequency counter with shared clock generator port logic
//
// How it works
// RULE_01: Power-on reset and clock stop return IF and gate pins to port use.
// RULE_02: Chip-enable reset leaves the pin function selection unchanged.
// RULE_03: Halt keeps pin configuration as it was before halt.
// RULE_04: Halt before the gate opens means the gate never opens.
// RULE_05: Software waits 1 ms after start before halting in IF mode.
// RULE_06: Software halts in gate mode only after the gate pin is high.
// RULE_07: No gate opening means no gate close event and no interrupt.
// RULE_08: Halt with only counter wake source and no event stays halted.
// RULE_09: Counter and clock port share hardware; only one runs at once.
// RULE_10: Nonzero mode write freezes port pin level and stops generation.
// RULE_11: Clearing mode to zero restarts clock port generation.
// RULE_12: In port mode, counter data reads undefined, writes ignored.
// RULE_13: Zero mode during counting makes the pin follow port pattern.
// RULE_14: Port output needs the port select flag set by software.
// RULE_15: Restoring mode resumes counting; pulses in port mode are lost.
// RULE_16: Pattern accesses never disturb counter; reads give last pattern.
// RULE_17: Pattern write takes bits 3..1 of both buffer nibbles.
// RULE_18: Gate close sets a flag that may raise the counter interrupt.
// RULE_19: IF mode counts rising input edges while the gate is open.
`timescale 1ns/1ps
module fcc_counter_port #(
    parameter int GATE_CYCLES = fcc_pkg::GATE_CYCLES,
    parameter int COUNT_W     = fcc_pkg::COUNT_W
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               clockStop,
    input  wire logic               ceReset,
    input  wire logic               haltActive,
    input  wire logic               modeWrite,
    input  wire logic [1:0]         modeWdata,
    input  wire logic               countStartFlag,
    input  wire logic               clockPortSelectFlag,
    input  wire logic               irqEnable,
    input  wire logic               irqFlagClear,
    input  wire logic               peripheralWriteOp,
    input  wire logic               peripheralReadOp,
    input  wire logic [7:0]         peripheralAddr,
    input  wire logic [7:0]         dataBufferWord,
    output logic      [7:0]         peripheralRdata,
    input  wire logic               fmIfInput,
    input  wire logic               amIfInput,
    input  wire logic               externalGateInput,
    output logic      [1:0]         ifPinCounterUse,
    output logic                    gatePinCounterUse,
    output logic                    clockGeneratorPort,
    output logic                    clockGeneratorPortEn,
    output logic                    gateOpen,
    output logic                    gateCloseIrqFlag,
    output logic                    counterIrq,
    output logic                    haltWake
);
    if (GATE_CYCLES < 1 || COUNT_W < 8 || COUNT_W > 32) begin : gBadParam
        $error("fcc_counter_port: unsupported parameter");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinSync;
    fcc_sync #(.WIDTH(3)) uSync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({externalGateInput, amIfInput, fmIfInput}),
        .syncOut (pinSync)
    );

    // ------------------------------------------------------------
    // Mode and pin function
    // ------------------------------------------------------------
    logic [1:0] countModeReg;
    logic [1:0] countMode_next;
    logic       countModeBitHigh;
    logic       countModeBitLow;
    logic       portMode;
    assign countModeBitHigh = countModeReg[1];
    assign countModeBitLow  = countModeReg[0];
    assign portMode         = (countModeReg == fcc_pkg::MODE_CLOCK_PORT); // RULE_09

    // Halt blocks mode writes so the pin setup stays put; clock stop still resets the mode
    always_comb begin
        countMode_next = countModeReg;
        if (clockStop) begin
            countMode_next = fcc_pkg::MODE_CLOCK_PORT; // RULE_01
        end else if (modeWrite && !haltActive) begin
            countMode_next = modeWdata; // RULE_03
        end
    end

    // Chip-enable reset is not wired to rst_b, so mode survives it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            countModeReg <= fcc_pkg::MODE_CLOCK_PORT; // RULE_01
        end else begin
            countModeReg <= countMode_next; // RULE_02
        end
    end

    assign ifPinCounterUse   = {!portMode && !countModeBitLow,
                                !portMode && countModeBitLow && !countModeBitHigh};
    assign gatePinCounterUse = countModeBitHigh && countModeBitLow;

    // ------------------------------------------------------------
    // Gate sequencing
    // ------------------------------------------------------------
    fcc_pkg::fcc_gate_type gateState_reg;
    fcc_pkg::fcc_gate_type gateState_next;
    logic [31:0]           gateCnt_reg;
    logic                  extGateMode;
    logic                  gatePinPrev_reg;
    logic                  gateRise;
    logic                  gateTimeUp;
    logic                  closeEvent;
    assign extGateMode = gatePinCounterUse;
    assign gateRise    = pinSync[2] && !gatePinPrev_reg;
    assign gateTimeUp  = (gateCnt_reg == 32'(GATE_CYCLES - 1));

    always_comb begin
        gateState_next = gateState_reg;
        closeEvent     = 1'b0;
        unique case (gateState_reg)
            fcc_pkg::FCC_IDLE: begin
                if (countStartFlag && !portMode && !ceReset) begin
                    gateState_next = fcc_pkg::FCC_ARMED;
                end
            end
            fcc_pkg::FCC_ARMED: begin
                // Halt before opening drops the measurement, even after halt ends
                if (haltActive) begin
                    gateState_next = fcc_pkg::FCC_IDLE; // RULE_04
                end else if (!portMode && (!extGateMode || gateRise)) begin
                    gateState_next = fcc_pkg::FCC_OPEN;
                end
            end
            fcc_pkg::FCC_OPEN: begin
                if (extGateMode ? gateRise : gateTimeUp) begin
                    gateState_next = fcc_pkg::FCC_DONE;
                    closeEvent     = 1'b1; // RULE_07
                end
            end
            fcc_pkg::FCC_DONE: begin
                if (countStartFlag && !portMode) begin
                    gateState_next = fcc_pkg::FCC_ARMED;
                end
            end
        endcase
        if (clockStop) begin
            gateState_next = fcc_pkg::FCC_IDLE;
            closeEvent     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gateState_reg   <= fcc_pkg::FCC_IDLE;
            gateCnt_reg     <= '0;
            gatePinPrev_reg <= 1'b0;
        end else begin
            gateState_reg   <= gateState_next;
            gatePinPrev_reg <= pinSync[2];
            if (gateState_reg != fcc_pkg::FCC_OPEN) begin
                gateCnt_reg <= '0;
            end else if (!portMode) begin
                gateCnt_reg <= gateCnt_reg + 32'h1;
            end
        end
    end

    assign gateOpen = (gateState_reg == fcc_pkg::FCC_OPEN);

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] countReg;
    logic               ifPrev_reg;
    logic               ifSel;
    logic               ifRise;
    logic [1:0]         refDiv_reg;
    logic               refFall;
    logic               countTick;
    assign ifSel     = countModeBitLow ? pinSync[0] : pinSync[1];
    assign ifRise    = ifSel && !ifPrev_reg;
    assign refFall   = (refDiv_reg == 2'h3);
    assign countTick = extGateMode ? refFall : ifRise; // RULE_19

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            countReg   <= '0;
            ifPrev_reg <= 1'b0;
            refDiv_reg <= 2'h0;
        end else begin
            ifPrev_reg <= ifSel;
            refDiv_reg <= refDiv_reg + 2'h1;
            if (countStartFlag && gateState_reg != fcc_pkg::FCC_OPEN) begin
                countReg <= '0;
            end else if (gateOpen && !portMode && countTick) begin
                countReg <= countReg + COUNT_W'(1); // RULE_15
            end
        end
    end

    // ------------------------------------------------------------
    // Gate close flag and interrupt
    // ------------------------------------------------------------
    logic irqFlag_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqFlag_reg <= 1'b0;
        end else if (closeEvent) begin
            irqFlag_reg <= 1'b1; // RULE_18
        end else if (irqFlagClear) begin
            irqFlag_reg <= 1'b0;
        end
    end
    assign gateCloseIrqFlag = irqFlag_reg;
    assign counterIrq       = irqFlag_reg && irqEnable; // RULE_18
    // Only the flag can wake; no flag, no wake
    assign haltWake         = counterIrq; // RULE_08

    // ------------------------------------------------------------
    // Clock generator port
    // ------------------------------------------------------------
    logic [2:0] patternReg;
    logic       patternUsed_reg;
    logic [1:0] portDiv_reg;
    logic [1:0] portPhase_reg;
    logic       portOut_reg;
    logic       patternWrite;
    logic       countRead;
    logic       portRun;
    assign patternWrite = peripheralWriteOp
                        && peripheralAddr == fcc_pkg::CLOCK_PORT_PATTERN_ADDR;
    assign countRead    = peripheralAddr == fcc_pkg::FREQ_COUNT_DATA_ADDR;
    assign portRun      = portMode && clockPortSelectFlag; // RULE_14

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            patternReg      <= fcc_pkg::PATTERN_RESET;
            patternUsed_reg <= 1'b0;
            portDiv_reg     <= 2'h0;
            portPhase_reg   <= 2'h0;
            portOut_reg     <= 1'b0;
        end else begin
            if (patternWrite) begin
                patternReg <= dataBufferWord[fcc_pkg::PATTERN_LSB +: fcc_pkg::PATTERN_W]
                            | dataBufferWord[4 + fcc_pkg::PATTERN_LSB +: fcc_pkg::PATTERN_W]; // RULE_17
            end
            if (portRun) begin
                patternUsed_reg <= 1'b1;
                portDiv_reg     <= portDiv_reg + 2'h1; // RULE_11
                if (portDiv_reg == 2'(fcc_pkg::PORT_DIV_CYCLES - 1)) begin
                    portPhase_reg <= portPhase_reg + 2'h1;
                    portOut_reg   <= patternReg[portPhase_reg == 2'h3 ? 2'h0 : portPhase_reg]; // RULE_13
                end
            end
            // Nonzero mode: hold last level, no generation
        end
    end
    assign clockGeneratorPort   = portOut_reg; // RULE_10
    assign clockGeneratorPortEn = clockPortSelectFlag;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdata_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (peripheralReadOp) begin
            if (countRead) begin
                // Undefined in port mode; zero chosen
                rdata_reg <= portMode ? 8'h00 : countReg[7:0]; // RULE_12
            end else if (peripheralAddr == fcc_pkg::CLOCK_PORT_PATTERN_ADDR) begin
                // Unused pattern while counting is undefined; zero chosen
                rdata_reg <= (portMode || patternUsed_reg) ? {4'h0, patternReg, 1'b0}
                                                           : 8'h00; // RULE_16
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign peripheralRdata = rdata_reg;
endmodule // fcc_counter_port

/* core/fcc_pkg.sv */
// Package: constants for the frequency counter / clock port sharing block
package fcc_pkg;
    localparam logic [7:0] CLOCK_PORT_PATTERN_ADDR = 8'h20;
    localparam logic [7:0] FREQ_COUNT_DATA_ADDR    = 8'h21;
    localparam int         PATTERN_LSB             = 1;
    localparam int         PATTERN_W               = 3;
    localparam logic [2:0] PATTERN_RESET           = 3'h0;
    localparam int         COUNT_W                 = 16;
    localparam logic [1:0] MODE_CLOCK_PORT         = 2'h0;
    localparam logic [1:0] MODE_EXT_GATE           = 2'h3;
    localparam int         CLK_MHZ                 = 200;
    localparam int         GATE_TIME_US            = 1000;
    localparam int         GATE_CYCLES             = GATE_TIME_US * CLK_MHZ;
    localparam int         PORT_DIV_CYCLES         = 4;
    typedef enum logic [1:0] {FCC_IDLE, FCC_ARMED, FCC_OPEN, FCC_DONE} fcc_gate_type;
endpackage

/* core/fcc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    if (WIDTH < 1) begin : gBadWidth
        $error("fcc_sync: unsupported width");
    end

    logic [WIDTH-1:0] stage1_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule // fcc_sync

/* dv/fcc_counter_port_chk.sv */
// Checker: port-level properties of the counter / clock port block
`timescale 1ns/1ps
module fcc_counter_port_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       clockStop,
    input wire logic       ceReset,
    input wire logic       haltActive,
    input wire logic       modeWrite,
    input wire logic [1:0] modeWdata,
    input wire logic       clockPortSelectFlag,
    input wire logic       irqEnable,
    input wire logic [1:0] ifPinCounterUse,
    input wire logic       gatePinCounterUse,
    input wire logic       clockGeneratorPort,
    input wire logic       clockGeneratorPortEn,
    input wire logic       gateOpen,
    input wire logic       gateCloseIrqFlag,
    input wire logic       counterIrq,
    input wire logic       haltWake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_countWrite;
        modeWrite && modeWdata != 2'h0 && !haltActive && !clockStop;
    endsequence
    sequence s_quiet;
        !modeWrite && !clockStop;
    endsequence
    property p_stopPins;
        clockStop |=> ifPinCounterUse == 2'h0 && !gatePinCounterUse;
    endproperty
    property p_cePins;
        ceReset && !modeWrite && !clockStop |=> $stable(ifPinCounterUse) && $stable(gatePinCounterUse);
    endproperty
    property p_haltPins;
        haltActive && !clockStop |=> $stable(ifPinCounterUse) && $stable(gatePinCounterUse);
    endproperty
    property p_haltNoOpen;
        haltActive && !gateOpen |=> !gateOpen;
    endproperty
    property p_noOpenNoIrq;
        $rose(gateCloseIrqFlag) |-> $past(gateOpen) || $past(gateOpen, 2);
    endproperty
    property p_irq;
        counterIrq == (gateCloseIrqFlag && irqEnable);
    endproperty
    property p_noWake;
        !gateCloseIrqFlag |-> !haltWake;
    endproperty
    property p_freeze;
        s_countWrite ##1 s_quiet [*3] |-> $stable(clockGeneratorPort);
    endproperty
    property p_portEn;
        !clockPortSelectFlag |-> !clockGeneratorPortEn ##1 $stable(clockGeneratorPort);
    endproperty
    a_stopPins: assert property (p_stopPins) else $error("pins kept counter use");
    a_cePins: assert property (p_cePins) else $error("pin use changed on ce reset");
    a_haltPins: assert property (p_haltPins) else $error("pin use changed in halt");
    a_haltNoOpen: assert property (p_haltNoOpen) else $error("gate opened in halt");
    a_noOpenNoIrq: assert property (p_noOpenNoIrq) else $error("flag without gate");
    a_irq: assert property (p_irq) else $error("counter irq wrong");
    a_noWake: assert property (p_noWake) else $error("halt wake without flag");
    a_freeze: assert property (p_freeze) else $error("port moved in count mode");
    a_portEn: assert property (p_portEn) else $error("port driven unselected");
endmodule // fcc_counter_port_chk

bind fcc_counter_port fcc_counter_port_chk chk_u (.clk, .rst_b, .clockStop, .ceReset,
    .haltActive, .modeWrite, .modeWdata, .clockPortSelectFlag, .irqEnable, .ifPinCounterUse,
    .gatePinCounterUse, .clockGeneratorPort, .clockGeneratorPortEn, .gateOpen,
    .gateCloseIrqFlag, .counterIrq, .haltWake);

/* dv/fcc_if_source.sv */
// Model of the tuner IF outputs and the external gate driver
`timescale 1ns/1ps
module fcc_if_source #(
    parameter realtime HALF = 10.0
) (
    input  wire logic run,
    input  wire logic gateReq,
    output logic      fmIfInput,
    output logic      amIfInput,
    output logic      externalGateInput
);
    logic wave = 1'b0;
    // Free running carrier of four system clock periods, its edges aligned to falling clock edges
    always #(HALF) wave = run ? ~wave : 1'b0;
    assign fmIfInput = wave;
    assign amIfInput = ~wave;
    assign externalGateInput = gateReq;
endmodule // fcc_if_source

/* dv/fcc_counter_port_tb.sv */
// Testbench: random and corner stimulus for the counter / clock port block
`timescale 1ns/1ps
module fcc_counter_port_tb;
    localparam int GATE = 20;
    localparam int REF_DIV = 4;
    localparam int EXT_GAP = 18;
    logic clk = 1'b0, rst_b = 1'b0, clockStop = 1'b0, ceReset = 1'b0, haltActive = 1'b0;
    logic modeWrite = 1'b0, countStartFlag = 1'b0, clockPortSelectFlag = 1'b0;
    logic irqEnable = 1'b0, irqFlagClear = 1'b0, peripheralWriteOp = 1'b0;
    logic peripheralReadOp = 1'b0, ifRun = 1'b1, gateReq = 1'b0, sawOpen = 1'b0;
    logic [1:0] modeWdata = 2'h0, ifPinCounterUse;
    logic [7:0] peripheralAddr = 8'h00, dataBufferWord = 8'h00, peripheralRdata, d;
    logic fmIfInput, amIfInput, externalGateInput, gatePinCounterUse, clockGeneratorPort;
    logic clockGeneratorPortEn, gateOpen, gateCloseIrqFlag, counterIrq, haltWake, lastPort;
    int seed = 95, failCount = 0, totalChecks = 0, cycles = 0, toggles = 0;

    always #2.5 clk = ~clk;
    fcc_if_source src_u (.run(ifRun), .gateReq(gateReq), .fmIfInput(fmIfInput),
        .amIfInput(amIfInput), .externalGateInput(externalGateInput));
    fcc_counter_port #(.GATE_CYCLES(GATE)) dut_u (.clk(clk), .rst_b(rst_b),
        .clockStop(clockStop), .ceReset(ceReset), .haltActive(haltActive),
        .modeWrite(modeWrite), .modeWdata(modeWdata), .countStartFlag(countStartFlag),
        .clockPortSelectFlag(clockPortSelectFlag), .irqEnable(irqEnable),
        .irqFlagClear(irqFlagClear), .peripheralWriteOp(peripheralWriteOp),
        .peripheralReadOp(peripheralReadOp), .peripheralAddr(peripheralAddr),
        .dataBufferWord(dataBufferWord), .peripheralRdata(peripheralRdata),
        .fmIfInput(fmIfInput), .amIfInput(amIfInput), .externalGateInput(externalGateInput),
        .ifPinCounterUse(ifPinCounterUse), .gatePinCounterUse(gatePinCounterUse),
        .clockGeneratorPort(clockGeneratorPort), .clockGeneratorPortEn(clockGeneratorPortEn),
        .gateOpen(gateOpen), .gateCloseIrqFlag(gateCloseIrqFlag), .counterIrq(counterIrq),
        .haltWake(haltWake));

    // ----------------------------------------
    // Monitors and helpers
    // ----------------------------------------
    // Sampled off the launching edge so registered outputs have settled
    always @(negedge clk) begin
        cycles++;
        lastPort <= clockGeneratorPort;
        if (clockGeneratorPort !== lastPort) toggles++;
        if (gateOpen === 1'b1) sawOpen <= 1'b1;
        if (cycles == 20000) begin
            failCount++;
            printVerdict();
        end
    end
    task automatic tick(input int n); repeat (n) @(negedge clk); endtask
    task automatic wrMode(input logic [1:0] m);
        modeWdata = m;
        modeWrite = 1'b1;
        tick(1);
        modeWrite = 1'b0;
    endtask
    task automatic pAcc(input logic w, input logic [7:0] a, input logic [7:0] v);
        peripheralAddr = a;
        dataBufferWord = v;
        peripheralWriteOp = w;
        peripheralReadOp = !w;
        tick(1);
        {peripheralWriteOp, peripheralReadOp} = 2'h0;
        tick(1);
    endtask
    task automatic pulse(input int k);
        {countStartFlag, clockStop, ceReset, irqFlagClear} = 4'h8 >> k;
        tick(1);
        {countStartFlag, clockStop, ceReset, irqFlagClear} = 4'h0;
    endtask
    task automatic waitFlag(input int n);
        for (int k = 0; k < n && gateCloseIrqFlag !== 1'b1; k++) tick(1);
    endtask
    task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    function automatic logic [2:0] patOf(input logic [7:0] v); return v[3:1] | v[7:5]; endfunction
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        tick(8);
        rst_b = 1'b1;
        tick(2);
        cmp("pinUse", 16'h0, {ifPinCounterUse, gatePinCounterUse});
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            pAcc(1'b1, fcc_pkg::CLOCK_PORT_PATTERN_ADDR, d);
            pAcc(1'b0, fcc_pkg::CLOCK_PORT_PATTERN_ADDR, 8'h00);
            cmp("pattern", patOf(d), peripheralRdata[fcc_pkg::PATTERN_LSB +: fcc_pkg::PATTERN_W]);
        end
        $display("test pattern done");
        clockPortSelectFlag = 1'b1;
        pAcc(1'b1, fcc_pkg::CLOCK_PORT_PATTERN_ADDR, 8'h0a);
        pAcc(1'b1, fcc_pkg::FREQ_COUNT_DATA_ADDR, 8'($random(seed)));
        pAcc(1'b0, fcc_pkg::FREQ_COUNT_DATA_ADDR, 8'h00);
        cmp("countInPortMode", 16'h0, peripheralRdata);
        toggles = 0;
        tick(40);
        cmp("portRuns", 16'h1, toggles > 0);
        wrMode(2'h2);
        tick(2);
        toggles = 0;
        pAcc(1'b0, fcc_pkg::CLOCK_PORT_PATTERN_ADDR, 8'h00);
        cmp("patternKept", 16'h5, peripheralRdata[fcc_pkg::PATTERN_LSB +: fcc_pkg::PATTERN_W]);
        tick(40);
        cmp("portFrozen", 16'h0, toggles);
        wrMode(fcc_pkg::MODE_CLOCK_PORT);
        toggles = 0;
        tick(40);
        cmp("portResumed", 16'h1, toggles > 0);
        $display("test sharing done");
        wrMode(2'h1);
        irqEnable = 1'b1;
        pulse(0);
        tick(4);
        haltActive = 1'b1;
        waitFlag(GATE + 50);
        cmp("wake", 16'h1, haltWake);
        cmp("irq", 16'h1, counterIrq);
        haltActive = 1'b0;
        pAcc(1'b0, fcc_pkg::FREQ_COUNT_DATA_ADDR, 8'h00);
        d = peripheralRdata;
        cmp("countRange", 16'h1, d >= GATE / 4 && d <= GATE / 4 + 1);
        pulse(3);
        tick(1);
        sawOpen = 1'b0;
        haltActive = 1'b1;
        pulse(0);
        tick(GATE + 20);
        cmp("gateInHalt", 16'h0, sawOpen);
        cmp("flagInHalt", 16'h0, gateCloseIrqFlag);
        cmp("wakeInHalt", 16'h0, haltWake);
        pulse(1);
        haltActive = 1'b0;
        cmp("stopPins", 16'h0, {ifPinCounterUse, gatePinCounterUse});
        $display("test halt done");
        wrMode(fcc_pkg::MODE_EXT_GATE);
        pulse(2);
        cmp("cePins", 16'h1, gatePinCounterUse);
        haltActive = 1'b1;
        wrMode(fcc_pkg::MODE_CLOCK_PORT);
        cmp("haltPins", 16'h1, gatePinCounterUse);
        haltActive = 1'b0;
        pulse(0);
        gateReq = 1'b1;
        tick(10);
        haltActive = 1'b1;
        gateReq = 1'b0;
        tick(EXT_GAP - 10);
        gateReq = 1'b1;
        waitFlag(40);
        cmp("extFlag", 16'h1, gateCloseIrqFlag);
        haltActive = 1'b0;
        pAcc(1'b0, fcc_pkg::FREQ_COUNT_DATA_ADDR, 8'h00);
        d = peripheralRdata;
        cmp("extCount", 16'h1, d >= EXT_GAP / REF_DIV && d <= EXT_GAP / REF_DIV + 1);
        $display("test external gate done");
        printVerdict();
    end
endmodule // fcc_counter_port_tb
